// ---- design/lcs_logic_cell.sv ----
`timescale 1ns/1ps
module lcs_logic_cell #(
    parameter int NC = lcs_pkg::NUM_CELLS,
    parameter int NL = lcs_pkg::NUM_LINES
) (
    // clock and reset
    input  wire logic                          i_ref_clk,
    input  wire logic                          i_arst_n,
    // cell data
    input  wire logic [NC-1:0]                 i_lut_out,
    input  wire logic [NC-1:0]                 i_bypass_input,
    // shared storage controls
    input  wire logic                          i_shared_clk,
    input  wire logic                          i_clk_en,
    input  wire logic                          i_async_wipe,
    input  wire lcs_pkg::lcs_cell_cfg_s [NC-1:0] i_cell_cfg,
    // global wipe sources
    input  wire logic                          i_global_wipe_pin,
    input  wire logic                          i_global_wipe_node,
    input  wire lcs_pkg::lcs_gw_cfg_s          i_gw_cfg,
    input  wire logic                          i_reconfig,
    // longline drivers
    input  wire logic [NC-1:0]                 i_drv_in,
    input  wire logic                          i_tristate_ctl,
    input  wire lcs_pkg::lcs_drv_cfg_s [NC-1:0] i_drv_cfg,
    // resolved longline levels
    input  wire logic [NL-1:0]                 i_line_level,
    // cell outputs
    output logic [NC-1:0]                      o_stored_q,
    output logic [NC-1:0]                      o_comb_out,
    output logic [NC-1:0]                      o_bypass_out,
    // longline side
    output logic [NC-1:0]                      o_drv_val,
    output logic [NC-1:0]                      o_drv_oe,
    output logic [NL-1:0]                      o_line_val,
    output logic [NL-1:0]                      o_line_oe,
    output logic [NL-1:0]                      o_keeper_val
);

    logic rst_s1_reg;
    logic rst_n_sync;
    logic ck_prev_reg;
    logic [NL-1:0] keep_reg;
    logic [NL-1:0] keep_next;
    logic [NL-1:0] line_val_w;

    localparam int HL = lcs_pkg::H_LINE_LO;
    localparam int VL = lcs_pkg::V_LINE_LO;

    // reset release through two flops
    always_ff @(posedge i_ref_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            rst_s1_reg <= 1'b0;
            rst_n_sync <= 1'b0;
        end
        else
        begin
            rst_s1_reg <= 1'b1;
            rst_n_sync <= rst_s1_reg;
        end
    end

    // power-up is covered by the reset itself, so only the live sources remain here
    wire gw_pin   = i_global_wipe_pin ^ i_gw_cfg.pin_invert;
    wire gw_src   = i_gw_cfg.from_node ? i_global_wipe_node : gw_pin;
    wire gw_total = gw_src | i_reconfig;

    // shared clock sampled as a data input; edge seen against last sample
    always_ff @(posedge i_ref_clk or negedge rst_n_sync)
    begin
        if (!rst_n_sync)
            ck_prev_reg <= lcs_pkg::CK_PRV_RST;
        else
            ck_prev_reg <= i_shared_clk;
    end

    genvar g;
    generate
        for (g = 0; g < NC; g++)
        begin : g_cell
            wire d_sel = i_cell_cfg[g].src_bypass ? i_bypass_input[g] : i_lut_out[g];
            lcs_store_cell u_store (
                .i_ref_clk (i_ref_clk),
                .i_rst_n   (rst_n_sync),
                .i_d       (d_sel),
                .i_ck_now  (i_shared_clk),
                .i_ck_prev (ck_prev_reg),
                .i_ce      (i_clk_en),
                .i_wipe    (i_async_wipe),
                .i_gwipe   (gw_total),
                .i_cfg     (i_cell_cfg[g]),
                .o_q       (o_stored_q[g])
            );
            assign o_drv_val[g] = i_drv_in[g];
            assign o_drv_oe[g]  = ~(i_drv_cfg[g].ts_mode & i_tristate_ctl);
        end
    endgenerate

    // no storage on these; they stay combinational by nature
    assign o_comb_out   = i_lut_out;
    assign o_bypass_out = i_bypass_input;

    // lines 0..1 horizontal, 2..3 vertical; lowest driver wins on self-contention
    always_comb
    begin
        o_line_oe  = '0;
        line_val_w = '0;
        for (int j = 0; j < NL; j++)
        begin
            for (int k = NC - 1; k >= 0; k--)
            begin
                if (o_drv_oe[k] && i_drv_cfg[k].line_mask[j])
                begin
                    o_line_oe[j]  = 1'b1;
                    line_val_w[j] = i_drv_in[k];
                end
            end
        end
    end

    assign o_line_val = line_val_w;

    // keeper follows the resolved wire so it holds the last driven level
    assign keep_next = i_line_level;

    always_ff @(posedge i_ref_clk or negedge rst_n_sync)
    begin
        if (!rst_n_sync)
            keep_reg <= {NL{lcs_pkg::KEEP_RST}};
        else
            keep_reg <= keep_next;
    end

    assign o_keeper_val = keep_reg;

    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (!rst_n_sync);

    feed_thru_a: assert property (o_bypass_out == i_bypass_input)
        else $error("bypass path altered");
    comb_out_a: assert property (o_comb_out == i_lut_out)
        else $error("combinatorial output not lookup result");
    ts_float_a: assert property (i_tristate_ctl && i_drv_cfg[0].ts_mode |-> !o_drv_oe[0])
        else $error("driver 0 not floated");
    ts_pass_a: assert property (!i_tristate_ctl |-> o_drv_oe == {NC{1'b1}}
        && o_drv_val == i_drv_in)
        else $error("driver not passing input");
    buf_mode_a: assert property (!i_drv_cfg[1].ts_mode |-> o_drv_oe[1])
        else $error("plain buffer was floated");
    line_reach_a: assert property (o_drv_oe[2] && i_drv_cfg[2].line_mask[3]
        |-> o_line_oe[3])
        else $error("driver did not reach line");
    // driver 0 has the lowest index, so it must own any line it reaches
    line_horiz_a: assert property (o_drv_oe[0] && i_drv_cfg[0].line_mask[HL]
        |-> o_line_oe[HL] && o_line_val[HL] == i_drv_in[0])
        else $error("lowest driver lost horizontal line");
    line_vert_a: assert property (o_drv_oe[0] && i_drv_cfg[0].line_mask[VL]
        |-> o_line_oe[VL] && o_line_val[VL] == i_drv_in[0])
        else $error("lowest driver lost vertical line");
    // keeper is still in reset on the release edge, hence the sampled reset term
    keep_hold_a: assert property (rst_n_sync && o_line_oe == '0
        && $stable(i_line_level) |=> o_keeper_val == $past(i_line_level))
        else $error("keeper lost line level");
    gw_pin_a: assert property (!i_gw_cfg.from_node && !i_reconfig
        && (i_global_wipe_pin != i_gw_cfg.pin_invert) |=> o_stored_q == '0)
        else $error("pin global wipe not applied");
    gw_node_a: assert property (i_gw_cfg.from_node && i_global_wipe_node
        ##1 i_gw_cfg.from_node && i_global_wipe_node |=> o_stored_q == '0)
        else $error("node global wipe not applied");
    reconf_wipe_a: assert property (i_reconfig |=> o_stored_q == '0)
        else $error("reconfiguration did not wipe stores");
    byp_src_a: assert property (rst_n_sync && i_cell_cfg[0].src_bypass
        && i_cell_cfg[0].latch_mode && (i_shared_clk == i_cell_cfg[0].clk_falling)
        && i_clk_en && !gw_total && !i_async_wipe
        |=> o_stored_q[0] == $past(i_bypass_input[0]))
        else $error("store did not take bypass input");
    lut_src_a: assert property (rst_n_sync && !i_cell_cfg[1].src_bypass
        && i_cell_cfg[1].latch_mode && (i_shared_clk == i_cell_cfg[1].clk_falling)
        && i_clk_en && !gw_total && !i_async_wipe
        |=> o_stored_q[1] == $past(i_lut_out[1]))
        else $error("store did not take lookup result");

endmodule : lcs_logic_cell

// ---- design/lcs_pkg.sv ----
// Operation
// - each store picks its data from the lookup result or the bypass input
// - four bypass inputs reach four bypass outputs with no storage between
// - each cell always shows its lookup result on a combinatorial output
// - four stores share one clock and one enable, each flop or latch
// - a store may be set to clock always, ignoring the shared enable
// - each store picks rising or falling edge of the shared clock
// - shared enable is active high, never inverted; store updates only when high
// - a store whose enable is unconnected sees the enable as always high
// - shared active high clear forces all four stores to zero
// - each store may be set to ignore the shared clear
// - global wipe clears every store at power-up, reconfiguration, or when driven
// - global wipe comes from a pin, optionally inverted, or an internal node
// - each longline driver is always-on buffer or three-state, by its own bit
// - one block three-state control gates every driver in three-state mode
// - control high floats the driver; control low passes its input unchanged
// - each driver may reach up to two horizontal and two vertical lines
// - weak keepers hold each line's last level; any enabled driver wins
// - stores read zero after reset or clear, hold when disabled, flops load on edge
// - latch is open at inactive clock level with enable, holds at active level
package lcs_pkg;

    localparam int NUM_CELLS = 4;
    localparam int NUM_LINES = 4;
    localparam int H_LINE_LO = 0;
    localparam int V_LINE_LO = 2;
    localparam logic Q_RST    = 1'h0;
    localparam logic KEEP_RST = 1'h0;
    localparam logic CK_PRV_RST = 1'h0;

    typedef struct packed {
        logic src_bypass;
        logic latch_mode;
        logic ce_always;
        logic ce_unconn;
        logic clk_falling;
        logic wipe_off;
    } lcs_cell_cfg_s;

    typedef struct packed {
        logic       ts_mode;
        logic [3:0] line_mask;
    } lcs_drv_cfg_s;

    typedef struct packed {
        logic from_node;
        logic pin_invert;
    } lcs_gw_cfg_s;

endpackage : lcs_pkg

// ---- design/lcs_store_cell.sv ----
`timescale 1ns/1ps
module lcs_store_cell (
    // clock and synced reset
    input  wire logic                  i_ref_clk,
    input  wire logic                  i_rst_n,
    // data and shared controls
    input  wire logic                  i_d,
    input  wire logic                  i_ck_now,
    input  wire logic                  i_ck_prev,
    input  wire logic                  i_ce,
    input  wire logic                  i_wipe,
    input  wire logic                  i_gwipe,
    input  wire lcs_pkg::lcs_cell_cfg_s i_cfg,
    // stored output
    output logic                       o_q
);

    logic q_reg;
    logic q_next;

    wire ck_act   = ~i_cfg.clk_falling;
    wire edge_hit = (i_ck_now == ck_act) && (i_ck_prev != ck_act);
    wire en       = i_ce | i_cfg.ce_always | i_cfg.ce_unconn;
    wire wipe     = i_gwipe | (i_wipe & ~i_cfg.wipe_off);
    wire open_lat = i_ck_now != ck_act;
    wire load     = en & (i_cfg.latch_mode ? open_lat : edge_hit);

    // wipe checked first so clock activity can never win against it
    assign q_next = wipe ? lcs_pkg::Q_RST : (load ? i_d : q_reg);

    always_ff @(posedge i_ref_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            q_reg <= lcs_pkg::Q_RST;
        else
            q_reg <= q_next;
    end

    assign o_q = q_reg;

    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (!i_rst_n);

    clr_zero_a: assert property (i_wipe && !i_cfg.wipe_off |=> o_q == 1'b0)
        else $error("clear did not zero store");
    clr_off_a: assert property (i_wipe && i_cfg.wipe_off && !i_gwipe && !load
        |=> $stable(o_q))
        else $error("disabled clear changed store");
    // store is still held in reset on the release edge, so load checks wait one edge
    gw_zero_a: assert property (i_gwipe [*2] |-> o_q == 1'b0)
        else $error("global wipe did not hold zero");
    ff_load_a: assert property (i_rst_n && !i_cfg.latch_mode && edge_hit && i_ce
        && !wipe |=> o_q == $past(i_d))
        else $error("flop missed load on active edge");
    ce_hold_a: assert property (!i_ce && !i_cfg.ce_always && !i_cfg.ce_unconn && !wipe
        |=> $stable(o_q))
        else $error("store moved with enable low");
    ce_force_a: assert property ((i_cfg.ce_always || i_cfg.ce_unconn) && !i_ce
        && !i_cfg.latch_mode && edge_hit && !wipe && i_rst_n |=> o_q == $past(i_d))
        else $error("forced enable not honoured");
    neg_pol_a: assert property (i_cfg.clk_falling && !i_cfg.latch_mode && !wipe
        && !i_ck_prev && i_ck_now |=> $stable(o_q))
        else $error("falling flop took rising edge");
    lat_open_a: assert property (i_rst_n && i_cfg.latch_mode && open_lat && en && !wipe
        |=> o_q == $past(i_d))
        else $error("latch not transparent");
    lat_shut_a: assert property (i_cfg.latch_mode && !open_lat && !wipe
        |=> $stable(o_q))
        else $error("latch moved at active level");

endmodule : lcs_store_cell

// ---- dv/lcs_line_model.sv ----
`timescale 1ns/1ps
module lcs_line_model (
    // this block's drive and keeper
    input  wire logic [3:0] i_line_oe,
    input  wire logic [3:0] i_line_val,
    input  wire logic [3:0] i_keeper_val,
    // a neighbouring block's drive
    input  wire logic [3:0] i_nb_oe,
    input  wire logic [3:0] i_nb_val,
    // resolved wire
    output logic      [3:0] o_level
);
    // own driver first; contention is kept out by giving it priority
    assign o_level = (i_line_oe & i_line_val) | (~i_line_oe & i_nb_oe & i_nb_val)
                   | (~i_line_oe & ~i_nb_oe & i_keeper_val);
endmodule : lcs_line_model

// ---- dv/lcs_logic_cell_tb_top.sv ----
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin errors++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
module lcs_logic_cell_tb_top;
    logic i_ref_clk = 1'h0, i_arst_n = 1'h0, i_shared_clk, i_clk_en, i_async_wipe;
    logic i_global_wipe_pin, i_global_wipe_node, i_reconfig, i_tristate_ctl;
    logic [3:0] i_lut_out, i_bypass_input, i_drv_in, nb_oe, nb_val, line_level;
    logic [3:0] o_stored_q, o_comb_out, o_bypass_out, o_drv_val, o_drv_oe;
    logic [3:0] o_line_val, o_line_oe, o_keeper_val, exp_q = 4'h0, prv, exp_keep = 4'h0;
    lcs_pkg::lcs_cell_cfg_s [3:0] i_cell_cfg;
    lcs_pkg::lcs_drv_cfg_s  [3:0] i_drv_cfg;
    lcs_pkg::lcs_gw_cfg_s         i_gw_cfg;
    logic [1:0] sync_reg = 2'h0;
    logic [7:0] exp_line;
    logic [31:0] seed = 32'h5;
    int errors = 0, cmp_count = 0;
    logic gw, act, en, d;
    always #5 i_ref_clk = ~i_ref_clk;
    lcs_logic_cell DUT (.i_ref_clk(i_ref_clk), .i_arst_n(i_arst_n), .i_lut_out(i_lut_out),
        .i_bypass_input(i_bypass_input), .i_shared_clk(i_shared_clk), .i_clk_en(i_clk_en),
        .i_async_wipe(i_async_wipe), .i_cell_cfg(i_cell_cfg),
        .i_global_wipe_pin(i_global_wipe_pin), .i_global_wipe_node(i_global_wipe_node),
        .i_gw_cfg(i_gw_cfg), .i_reconfig(i_reconfig), .i_drv_in(i_drv_in),
        .i_tristate_ctl(i_tristate_ctl), .i_drv_cfg(i_drv_cfg), .i_line_level(line_level),
        .o_stored_q(o_stored_q), .o_comb_out(o_comb_out), .o_bypass_out(o_bypass_out),
        .o_drv_val(o_drv_val), .o_drv_oe(o_drv_oe), .o_line_val(o_line_val),
        .o_line_oe(o_line_oe), .o_keeper_val(o_keeper_val));
    lcs_line_model u_line (.i_line_oe(o_line_oe), .i_line_val(o_line_val),
        .i_keeper_val(o_keeper_val), .i_nb_oe(nb_oe), .i_nb_val(nb_val), .o_level(line_level));
    function automatic logic [31:0] xorshift(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xorshift
    // {oe, val}: lowest driver index wins a line
    function automatic logic [7:0] line_exp(input logic [3:0] din, input logic ts);
        logic [7:0] r;
        r = 8'h00;
        for (int j = 3; j >= 0; j--)
        begin
            for (int k = 0; k < 4; k++)
            begin
                if (!(i_drv_cfg[j].ts_mode & ts) && i_drv_cfg[j].line_mask[k])
                begin
                    r[k + 4] = 1'h1;
                    r[k] = din[j];
                end
            end
        end
        return r;
    endfunction : line_exp
    // wipes kept rare so that loads are seen often
    task automatic drive(input logic forced);
        logic [31:0] a, b;
        a = xorshift(seed);
        b = xorshift(a);
        seed = b;
        {i_lut_out, i_bypass_input, i_drv_in, nb_oe, nb_val} <= a[19:0];
        {i_shared_clk, i_clk_en, i_tristate_ctl} <= a[22:20];
        i_async_wipe <= forced | (a[23] & a[24] & a[25]);
        i_reconfig <= a[26] & a[27] & a[28] & a[29] & ~forced;
        i_gw_cfg <= b[31:30];
        i_global_wipe_pin <= b[30] ^ (a[30] & a[31] & b[0]);
        i_global_wipe_node <= b[1] & b[2] & b[3] & ~forced;
        if (b[4] | forced)
        begin
            i_cell_cfg <= forced ? {4{6'h3f}} : b[28:5];
            i_drv_cfg <= a[31:12];
        end
    endtask : drive
    always @(posedge i_ref_clk or negedge i_arst_n)
        if (!i_arst_n) sync_reg <= 2'h0;
        else sync_reg <= {sync_reg[0], 1'h1};
    always @(posedge i_ref_clk)
    begin
        gw = i_reconfig | (i_gw_cfg.from_node ? i_global_wipe_node
                           : i_global_wipe_pin ^ i_gw_cfg.pin_invert);
        for (int c = 0; c < 4; c++)
        begin
            act = ~i_cell_cfg[c].clk_falling;
            en = i_clk_en | i_cell_cfg[c].ce_always | i_cell_cfg[c].ce_unconn;
            d = i_cell_cfg[c].src_bypass ? i_bypass_input[c] : i_lut_out[c];
            if (!sync_reg[1] || gw || (i_async_wipe && !i_cell_cfg[c].wipe_off)) exp_q[c] = 1'h0;
            else if (en && (i_cell_cfg[c].latch_mode ? i_shared_clk != act
                            : i_shared_clk == act && prv[c] != act)) exp_q[c] = d;
            prv[c] = sync_reg[1] & i_shared_clk;
        end
        exp_keep = sync_reg[1] ? line_level : 4'h0;
    end
    always @(negedge i_ref_clk)
    begin
        exp_line = line_exp(i_drv_in, i_tristate_ctl);
        if (i_arst_n) `CHK(o_stored_q, exp_q)
        else `CHK(o_stored_q, 4'h0)
        `CHK(o_comb_out, i_lut_out)
        `CHK(o_bypass_out, i_bypass_input)
        `CHK(o_drv_val, i_drv_in)
        `CHK(o_drv_oe, ~({i_drv_cfg[3].ts_mode, i_drv_cfg[2].ts_mode, i_drv_cfg[1].ts_mode,
                          i_drv_cfg[0].ts_mode} & {4{i_tristate_ctl}}))
        `CHK(o_line_oe, exp_line[7:4])
        `CHK(o_line_val & o_line_oe, exp_line[3:0])
        if (i_arst_n) `CHK(o_keeper_val, exp_keep)
        else `CHK(o_keeper_val, 4'h0)
    end
    task automatic print_verdict();
        $display("errors=%0d compares=%0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : print_verdict
    initial
    begin
        {i_lut_out, i_bypass_input, i_drv_in, nb_oe, nb_val} = 20'h0;
        {i_shared_clk, i_clk_en, i_async_wipe, i_reconfig, i_tristate_ctl} = 5'h0;
        {i_global_wipe_pin, i_global_wipe_node, i_gw_cfg} = 4'h0;
        i_cell_cfg = '0;
        i_drv_cfg = '0;
        repeat (4) @(posedge i_ref_clk);
        i_arst_n <= 1'h1;
        repeat (3000) @(posedge i_ref_clk) drive(1'h0);
        // reset again mid-run: stores and keepers must restart from zero
        i_arst_n <= 1'h0;
        repeat (3) @(posedge i_ref_clk) drive(1'h0);
        i_arst_n <= 1'h1;
        // clear held high on latches that ignore it: data must still pass
        repeat (40) @(posedge i_ref_clk) drive(1'h1);
        repeat (200) @(posedge i_ref_clk) drive(1'h0);
        print_verdict();
    end
    initial
    begin
        #100us;
        errors++;
        print_verdict();
    end
endmodule : lcs_logic_cell_tb_top
